// ==== rtl/status_output_function_selector.sv ====
// Status output function selector for four logic outputs and two relay coils
//
// Contract
// - Each of six outputs has own function code
// - Code 18: position feedback sensor failure
// - Code 19: cooling fan running
// - Code 20: cooling fan not working
// - Code 21: any trip declared
// - Code 22: self trip clear, automatic source only
// - Code 23: flux at least 75 percent
// - Code 24: DC bus fuse open
// - Code 25: phase current sum above 50 percent
// - Code 26: speed regulator in low gain
// - Code 27: torque limit while motoring
// - Code 28: motor overload curve exceeded
// - Code 29: always deasserted
// - Code 30: inverse of alarm
// - Code 31: normal terminal slowdown active
// - Code 32: phase current above 300 percent
// - Code 33: overspeed held for set duration
// - Code 34: heatsink above 90 C
// - Code 35: bus over 850 or 425 V
// - Code 36: heatsink above 80 C warning
// - Code 37: open motor phase detected
`timescale 1ns/1ps
module status_output_function_selector #(
    parameter int NUM_OUT = status_sel_pkg::NUM_OUT,
    parameter int MEAS_W = status_sel_pkg::MEAS_W,
    parameter int OSPD_CNT_W = status_sel_pkg::OSPD_CNT_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    // Function code per terminal: 0..3 logic outputs, 4..5 relay coils
    input wire logic [NUM_OUT*status_sel_pkg::CODE_W-1:0] func_sel,
    // Digital condition flags from the drive monitors
    input wire logic encoder_fault,
    input wire logic fan_running,
    input wire logic fan_failed,
    input wire logic trip_declared,
    input wire logic trip_clear_request,
    input wire logic trip_clear_source_setting,
    input wire logic fuse_open,
    input wire logic low_gain_active,
    input wire logic torque_limit_hit,
    input wire logic motoring_mode,
    input wire logic motor_overload,
    input wire logic alarm_present,
    input wire logic normal_terminal_slowdown,
    input wire logic phase_open,
    input wire logic class_460v,
    // Measurements, scaled to percent, degrees C and volts
    input wire logic [status_sel_pkg::PCT_W-1:0] flux_pct,
    input wire logic [status_sel_pkg::PCT_W-1:0] phase_sum_pct,
    input wire logic [MEAS_W-1:0] phase_curr_pct,
    input wire logic [MEAS_W-1:0] speed_pct,
    input wire logic [MEAS_W-1:0] overspeed_limit_pct,
    input wire logic [OSPD_CNT_W-1:0] overspeed_hold_cycles,
    input wire logic [MEAS_W-1:0] heatsink_temp_c,
    input wire logic [MEAS_W-1:0] bus_volts,
    output logic [status_sel_pkg::NUM_LOGIC-1:0] logic_out,
    output logic [status_sel_pkg::NUM_RELAY-1:0] relay_coil
);
    import status_sel_pkg::*;

    // ------------------------------------------------------------
    // Condition derivation
    // ------------------------------------------------------------
    logic cond_trip_clear;
    logic cond_flux_ok;
    logic cond_ground;
    logic cond_motor_trq;
    logic cond_over_curr;
    logic cond_overspeed;
    logic cond_overtemp_flt;
    logic cond_overtemp_alm;
    logic cond_overvolt;
    logic [MEAS_W-1:0] volt_limit;

    // A manual clear source masks any stray request from the monitors
    assign cond_trip_clear = trip_clear_request &&
        (trip_clear_source_setting == TRIP_CLEAR_AUTO);
    assign cond_flux_ok = (flux_pct >= FLUX_CONFIRM_PCT);
    assign cond_ground = (phase_sum_pct > GROUND_PCT);
    assign cond_motor_trq = torque_limit_hit && motoring_mode;
    assign cond_over_curr = (phase_curr_pct > MEAS_W'(OVER_CURR_PCT));
    assign cond_overtemp_flt = (heatsink_temp_c > MEAS_W'(OVERTEMP_FLT_C));
    assign cond_overtemp_alm = (heatsink_temp_c > MEAS_W'(OVERTEMP_ALM_C));
    assign volt_limit = class_460v ? MEAS_W'(OVERVOLT_460_V) : MEAS_W'(OVERVOLT_230_V);
    assign cond_overvolt = (bus_volts > volt_limit);

    // ------------------------------------------------------------
    // Overspeed persistence
    // ------------------------------------------------------------
    overspeed_timer #(
        .CNT_W(OSPD_CNT_W)
    ) u_overspeed (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .above_limit(speed_pct > overspeed_limit_pct),
        .hold_cycles(overspeed_hold_cycles),
        .overspeed(cond_overspeed)
    );

    // ------------------------------------------------------------
    // Per-terminal selection
    // ------------------------------------------------------------
    logic [NUM_OUT-1:0] out_q;
    logic [NUM_OUT-1:0] out_d;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            // Decoded in place so every condition is in the process sensitivity
            always_comb begin
                unique case (func_sel[gi*CODE_W +: CODE_W])
                    FN_ENCODER_FLT: out_d[gi] = encoder_fault;
                    FN_FAN_RUN: out_d[gi] = fan_running;
                    FN_FAN_ALARM: out_d[gi] = fan_failed;
                    FN_FAULT: out_d[gi] = trip_declared;
                    FN_TRIP_CLEAR_OUT: out_d[gi] = cond_trip_clear;
                    FN_FLUX_CONFIRM: out_d[gi] = cond_flux_ok;
                    FN_FUSE_FAULT: out_d[gi] = fuse_open;
                    FN_GROUND_FAULT: out_d[gi] = cond_ground;
                    FN_LOW_GAIN: out_d[gi] = low_gain_active;
                    FN_MOTOR_TRQ_LIM: out_d[gi] = cond_motor_trq;
                    FN_MTR_OVERLOAD: out_d[gi] = motor_overload;
                    FN_NO_FUNCTION: out_d[gi] = 1'b0;
                    FN_NOT_ALARM: out_d[gi] = !alarm_present;
                    FN_SLOWDOWN: out_d[gi] = normal_terminal_slowdown;
                    FN_OVER_CURR: out_d[gi] = cond_over_curr;
                    FN_OVERSPEED: out_d[gi] = cond_overspeed;
                    FN_OVERTEMP_FLT: out_d[gi] = cond_overtemp_flt;
                    FN_OVERVOLT: out_d[gi] = cond_overvolt;
                    FN_OVERTEMP_ALARM: out_d[gi] = cond_overtemp_alm;
                    FN_PHASE_LOSS: out_d[gi] = phase_open;
                    // Codes outside 18..37 belong to other selector stages; read as off here
                    default: out_d[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            out_q <= {NUM_OUT{OUT_RESET}};
        end else begin
            out_q <= out_d;
        end
    end

    assign logic_out = out_q[NUM_LOGIC-1:0];
    assign relay_coil = out_q[NUM_OUT-1:NUM_LOGIC];

endmodule

// ==== rtl/status_sel_pkg.sv ====
// Package with function codes, widths and thresholds for the status output selector
package status_sel_pkg;

    localparam int CODE_W = 6;
    localparam int NUM_LOGIC = 4;
    localparam int NUM_RELAY = 2;
    localparam int NUM_OUT = 6;

    // Function codes handled by this block
    localparam logic [5:0] FN_ENCODER_FLT = 6'h12;
    localparam logic [5:0] FN_FAN_RUN = 6'h13;
    localparam logic [5:0] FN_FAN_ALARM = 6'h14;
    localparam logic [5:0] FN_FAULT = 6'h15;
    localparam logic [5:0] FN_TRIP_CLEAR_OUT = 6'h16;
    localparam logic [5:0] FN_FLUX_CONFIRM = 6'h17;
    localparam logic [5:0] FN_FUSE_FAULT = 6'h18;
    localparam logic [5:0] FN_GROUND_FAULT = 6'h19;
    localparam logic [5:0] FN_LOW_GAIN = 6'h1a;
    localparam logic [5:0] FN_MOTOR_TRQ_LIM = 6'h1b;
    localparam logic [5:0] FN_MTR_OVERLOAD = 6'h1c;
    localparam logic [5:0] FN_NO_FUNCTION = 6'h1d;
    localparam logic [5:0] FN_NOT_ALARM = 6'h1e;
    localparam logic [5:0] FN_SLOWDOWN = 6'h1f;
    localparam logic [5:0] FN_OVER_CURR = 6'h20;
    localparam logic [5:0] FN_OVERSPEED = 6'h21;
    localparam logic [5:0] FN_OVERTEMP_FLT = 6'h22;
    localparam logic [5:0] FN_OVERVOLT = 6'h23;
    localparam logic [5:0] FN_OVERTEMP_ALARM = 6'h24;
    localparam logic [5:0] FN_PHASE_LOSS = 6'h25;

    // Measurement widths
    localparam int MEAS_W = 16;
    localparam int PCT_W = 8;

    // Thresholds (percent, degrees C, volts)
    localparam logic [7:0] FLUX_CONFIRM_PCT = 8'h4b;   // 75 %
    localparam logic [7:0] GROUND_PCT = 8'h32;         // 50 %
    localparam logic [15:0] OVER_CURR_PCT = 16'h012c;  // 300 %
    localparam logic [15:0] OVERTEMP_FLT_C = 16'h005a; // 90 C
    localparam logic [15:0] OVERTEMP_ALM_C = 16'h0050; // 80 C
    localparam logic [15:0] OVERVOLT_460_V = 16'h0352; // 850 V
    localparam logic [15:0] OVERVOLT_230_V = 16'h01a9; // 425 V

    // Trip clear source setting encoding
    localparam logic TRIP_CLEAR_AUTO = 1'b1;

    // Reset value of each output terminal
    localparam logic OUT_RESET = 1'b0;

    // Overspeed timer width
    localparam int OSPD_CNT_W = 24;

endpackage

// ==== rtl/overspeed_timer.sv ====
// Overspeed persistence timer: flags speed held above a limit for a set duration
`timescale 1ns/1ps
module overspeed_timer #(
    parameter int CNT_W = status_sel_pkg::OSPD_CNT_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic above_limit,
    input wire logic [CNT_W-1:0] hold_cycles,
    output logic overspeed
);
    import status_sel_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic hit_q;
    logic hit_d;

    // ------------------------------------------------------------
    // Persistence count
    // ------------------------------------------------------------
    // Any dip below the limit restarts the wait, so short spikes never flag
    always_comb begin
        cnt_d = cnt_q;
        hit_d = 1'b0;
        if (!above_limit) begin
            cnt_d = '0;
        end else if (cnt_q >= hold_cycles) begin
            hit_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign overspeed = hit_q;

endmodule

// ==== tb/terminal_reader.sv ====
// Controller-side model that latches the drive's output terminals
`timescale 1ns/1ps
module terminal_reader (
    input wire logic sys_clk,
    input wire logic [3:0] logic_out,
    input wire logic [1:0] relay_coil,
    output logic [5:0] seen
);
    // Terminals are plain levels, one flop each models a scanning controller input
    always_ff @(posedge sys_clk) begin
        seen <= {relay_coil, logic_out};
    end
endmodule

// ==== tb/status_sel_assertions.sv ====
// Concurrent checks on the status output selector terminals
`timescale 1ns/1ps
module status_sel_checker
    import status_sel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [35:0] func_sel,
    input wire logic trip_declared,
    input wire logic trip_clear_request,
    input wire logic trip_clear_source_setting,
    input wire logic alarm_present,
    input wire logic class_460v,
    input wire logic [7:0] flux_pct,
    input wire logic [15:0] bus_volts,
    input wire logic [3:0] logic_out,
    input wire logic [1:0] relay_coil
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // The flop is still in reset at the releasing edge, so that edge starts no check
    property p_fault; nrst && func_sel[5:0] == FN_FAULT |=>
        logic_out[0] == $past(trip_declared);
    endproperty
    property p_flux; nrst && func_sel[11:6] == FN_FLUX_CONFIRM |=>
        logic_out[1] == ($past(flux_pct) >= 8'h4b); endproperty
    property p_clear; nrst && func_sel[17:12] == FN_TRIP_CLEAR_OUT |=>
        logic_out[2] == ($past(trip_clear_request) & $past(trip_clear_source_setting));
    endproperty
    property p_not_alarm; nrst && func_sel[23:18] == FN_NOT_ALARM |=>
        logic_out[3] != $past(alarm_present); endproperty
    property p_none; func_sel[29:24] == FN_NO_FUNCTION |=> !relay_coil[0]; endproperty
    property p_volt; nrst && func_sel[35:30] == FN_OVERVOLT |=>
        relay_coil[1] == ($past(bus_volts) > ($past(class_460v) ? 16'h0352 : 16'h01a9));
    endproperty
    // Codes above the handled range must never light relay coil 1
    property p_refuse; func_sel[35:30] > FN_PHASE_LOSS |=> !relay_coil[1]; endproperty
    property p_reset; @(posedge sys_clk) disable iff (1'b0)
        !nrst |-> logic_out == 4'h0 && relay_coil == 2'h0; endproperty
    a_fault: assert property (p_fault) else $error("fault output wrong");
    a_flux: assert property (p_flux) else $error("flux output wrong");
    a_clear: assert property (p_clear) else $error("trip clear output wrong");
    a_not_alarm: assert property (p_not_alarm) else $error("not alarm wrong");
    a_none: assert property (p_none) else $error("no function output set");
    a_volt: assert property (p_volt) else $error("overvolt output wrong");
    a_refuse: assert property (p_refuse) else $error("unknown code output set");
    a_reset: assert property (p_reset) else $error("output set in reset");
    c_fault: cover property (func_sel[5:0] == FN_FAULT ##1 logic_out[0]);
    c_volt: cover property (func_sel[35:30] == FN_OVERVOLT ##1 relay_coil[1]);
    c_rst: cover property (@(posedge sys_clk) disable iff (1'b0) !nrst ##1 nrst);
endmodule
bind status_output_function_selector status_sel_checker chk (.sys_clk, .nrst, .func_sel,
    .trip_declared, .trip_clear_request, .trip_clear_source_setting, .alarm_present,
    .class_460v, .flux_pct, .bus_volts, .logic_out, .relay_coil);

// ==== tb/testbench.sv ====
// Self-checking bench for the status output selector
`timescale 1ns/1ps
module testbench;
    typedef struct {int due; logic [5:0] e;} note_t;
    note_t notes[$];
    note_t nt;
    logic sys_clk = 1'b0;
    // Starts high so the first reset step gives the flops a real falling edge
    logic nrst = 1'b1;
    logic [35:0] func_sel = 36'h0;
    logic [14:0] flg = 15'h0;
    logic [7:0] flux_pct = 8'h0, phase_sum_pct = 8'h0;
    logic [15:0] phase_curr_pct = 16'h0, heatsink_temp_c = 16'h0, bus_volts = 16'h0;
    logic [15:0] speed_pct = 16'h0;
    logic [3:0] logic_out;
    logic [1:0] relay_coil;
    logic [5:0] seen;
    int seed = 32'h12e13cf9, cyc = 0, miscompares = 0, num_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    status_output_function_selector uut (.sys_clk, .nrst, .func_sel,
        .encoder_fault(flg[0]), .fan_running(flg[1]), .fan_failed(flg[2]),
        .trip_declared(flg[3]), .trip_clear_request(flg[4]),
        .trip_clear_source_setting(flg[5]), .fuse_open(flg[6]), .low_gain_active(flg[7]),
        .torque_limit_hit(flg[8]), .motoring_mode(flg[9]), .motor_overload(flg[10]),
        .alarm_present(flg[11]), .normal_terminal_slowdown(flg[12]), .phase_open(flg[13]),
        .class_460v(flg[14]), .flux_pct, .phase_sum_pct, .phase_curr_pct, .speed_pct,
        .overspeed_limit_pct(16'h0064), .overspeed_hold_cycles(24'h000003),
        .heatsink_temp_c, .bus_volts, .logic_out, .relay_coil);
    terminal_reader ctrl (.sys_clk, .logic_out, .relay_coil, .seen);
    // Measurements straddle each threshold so both sides of every compare occur
    task automatic step(input logic rs, input logic fix, input logic o, input bit chk);
        logic [63:0] v;
        logic [35:0] fs;
        logic [5:0] e;
        logic [14:0] f;
        logic [7:0] fx, su;
        logic [15:0] cu, tp, vo;
        @(posedge sys_clk);
        f = 15'($random(seed));
        fx = 8'h46 + 8'({$random(seed)} % 10);
        su = 8'h2e + 8'({$random(seed)} % 8);
        cu = 16'h0128 + 16'({$random(seed)} % 8);
        tp = 16'h004c + 16'({$random(seed)} % 16);
        vo = (f[14] ? 16'h034d : 16'h01a4) + 16'({$random(seed)} % 10);
        v = 64'h0;
        v[37:18] = {f[13], tp > 16'h0050, vo > (f[14] ? 16'h0352 : 16'h01a9),
            tp > 16'h005a, o, cu > 16'h012c, f[12], !f[11], 1'b0,
            f[10], f[8] & f[9], f[7], su > 8'h32, f[6], fx >= 8'h4b,
            f[4] & f[5], f[3], f[2], f[1], f[0]};
        for (int i = 0; i < 6; i++) begin
            fs[6*i+:6] = fix ? 6'h21 : (($random(seed) & 7) == 0) ? 6'($random(seed))
                : 6'h12 + 6'({$random(seed)} % 20);
            e[i] = rs & v[fs[6*i+:6]];
        end
        // Async reset wipes the result the previous step would show next edge
        if (!rs && notes.size() > 0) notes[$].e = 6'h0;
        nrst <= rs;
        func_sel <= fs;
        flg <= f;
        flux_pct <= fx;
        phase_sum_pct <= su;
        phase_curr_pct <= cu;
        heatsink_temp_c <= tp;
        bus_volts <= vo;
        speed_pct <= fix ? 16'h00c8 : 16'h0000;
        if (chk) notes.push_back('{cyc + 3, e});
    endtask
    task check_out(input logic [5:0] exp, input logic [5:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH terminals expected %b seen %b", exp, got);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        #1;
        if (notes.size() > 0 && notes[0].due == cyc) begin
            nt = notes.pop_front();
            check_out(nt.e, seen);
        end
    end
    initial begin
        #15000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (12) step(0, 0, 0, 1);
        repeat (600) step(1, 0, 0, 1);
        repeat (3) step(0, 0, 0, 1);
        repeat (600) step(1, 0, 0, 1);
        // Overspeed flag lags the other codes, so only its ends are compared
        step(1, 1, 0, 1);
        repeat (10) step(1, 1, 0, 0);
        step(1, 1, 1, 1);
        repeat (4) step(1, 0, 0, 0);
        repeat (100) step(1, 0, 0, 1);
        repeat (4) @(posedge sys_clk);
        complete_run();
    end
endmodule
